// ==== logic/ddsrs_device.sv ====
// device end: word store, select, accumulator, square output control
`timescale 1ns/1ps
`default_nettype none
module ddsrs_device (
    input  wire logic                          sys_clk_i,     // master clock
    input  wire logic                          arst_n_i,      // async reset, low
    ddsrs_if.device                            link,          // host link
    input  wire logic                          comparator_i,  // on-chip comparator result
    output var  logic [ddsrs_pkg::PHASE_W-1:0] dac_code_o,    // dac amplitude code
    output var  logic                          mode_o,        // 1 triangle, 0 sine
    output var  logic [ddsrs_pkg::PHASE_W-1:0] phase_o        // offset phase
);
    // offset adds onto the top phase bits of the accumulator
    localparam int ACC_LSB = ddsrs_pkg::FREQ_W - ddsrs_pkg::PHASE_W;

    // one register image for the device, apart from the select pin samplers fpin_s and ppin_s
    typedef struct packed {
        logic [ddsrs_pkg::CTRL_W-1:0]  ctrl;
        logic [ddsrs_pkg::FREQ_W-1:0]  f0;
        logic [ddsrs_pkg::FREQ_W-1:0]  f1;
        logic [ddsrs_pkg::PHASE_W-1:0] p0;
        logic [ddsrs_pkg::PHASE_W-1:0] p1;
        logic [ddsrs_pkg::FREQ_W-1:0]  acc;
        logic [ddsrs_pkg::PHASE_W-1:0] ph;
        logic [ddsrs_pkg::PHASE_W-1:0] dac;
        logic                          msb_prev;
        logic                          half;
        logic                          sq;
        logic                          oe;
    } ddsrs_dev_t;

    ddsrs_dev_t st;
    ddsrs_dev_t next_st;
    logic       fpin_s;
    logic       ppin_s;

    // triangle from phase: rise on first half, fall on second
    function automatic logic [ddsrs_pkg::PHASE_W-1:0] tri_wave(
        input logic [ddsrs_pkg::PHASE_W-1:0] p
    );
        logic [ddsrs_pkg::PHASE_W-1:0] r;
        r = p[ddsrs_pkg::PHASE_W-1] ? ~p : p;
        return {r[ddsrs_pkg::PHASE_W-2:0], 1'b0};
    endfunction

    // sine lookup: half-wave parabola approximation
    function automatic logic [ddsrs_pkg::PHASE_W-1:0] sine_lookup(
        input logic [ddsrs_pkg::PHASE_W-1:0] p
    );
        logic [ddsrs_pkg::PHASE_W-2:0]   x;
        logic [2*ddsrs_pkg::PHASE_W-3:0] sq2;
        logic [ddsrs_pkg::PHASE_W-2:0]   m;
        x   = p[ddsrs_pkg::PHASE_W-2:0];
        sq2 = {{(ddsrs_pkg::PHASE_W-1){1'b0}}, x} * {{(ddsrs_pkg::PHASE_W-1){1'b0}}, x};
        m   = x - sq2[2*ddsrs_pkg::PHASE_W-3:ddsrs_pkg::PHASE_W-1];
        m   = {m[ddsrs_pkg::PHASE_W-3:0], 1'b0};
        // zero phase gives midscale; second half mirrors below it
        return p[ddsrs_pkg::PHASE_W-1] ? {1'b0, ~m} : {1'b1, m};
    endfunction

    // active select: pin level in pin mode, else the control bit
    function automatic logic pick_sel(
        input logic pin_mode,
        input logic pin_lvl,
        input logic ctrl_bit
    );
        return pin_mode ? pin_lvl : ctrl_bit;
    endfunction

    // =========================================================
    // select pin sampling on the falling clock edge
    // a change right at this edge may act one cycle later
    always_ff @(negedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            fpin_s <= 1'b0;
            ppin_s <= 1'b0;
        end else begin
            fpin_s <= link.freq_choice_pin;
            ppin_s <= link.phase_choice_pin;
        end
    end

    // =========================================================
    // next state
    always_comb begin
        logic                          freq_choice_bit;
        logic                          psel;
        logic [ddsrs_pkg::FREQ_W-1:0]  fword;
        logic [ddsrs_pkg::PHASE_W-1:0] poff;
        logic                          msb;
        logic                          dig;

        freq_choice_bit    = 1'b0;
        psel    = 1'b0;
        fword   = '0;
        poff    = '0;
        msb     = 1'b0;
        dig     = 1'b0;
        next_st = st;

        // =========================================================
        // word loads from the host
        if (link.wr_en) begin
            unique case (link.wr_sel)
                ddsrs_pkg::DDSRS_LD_CTRL: next_st.ctrl = link.wr_data[ddsrs_pkg::CTRL_W-1:0];
                ddsrs_pkg::DDSRS_LD_F0:   next_st.f0 = link.wr_data;
                ddsrs_pkg::DDSRS_LD_F1:   next_st.f1 = link.wr_data;
                ddsrs_pkg::DDSRS_LD_P0: begin
                    next_st.p0 = link.wr_data[ddsrs_pkg::PHASE_W-1:0];
                end
                ddsrs_pkg::DDSRS_LD_P1: begin
                    next_st.p1 = link.wr_data[ddsrs_pkg::PHASE_W-1:0];
                end
                default: ;
            endcase
        end

        // =========================================================
        // pins or control bits govern selection
        freq_choice_bit  = pick_sel(st.ctrl[ddsrs_pkg::CB_PINSW], fpin_s, st.ctrl[ddsrs_pkg::CB_FREQ_CHOICE_BIT]);
        psel  = pick_sel(st.ctrl[ddsrs_pkg::CB_PINSW], ppin_s, st.ctrl[ddsrs_pkg::CB_PSEL]);
        fword = freq_choice_bit ? st.f1 : st.f0;
        poff  = psel ? st.p1 : st.p0;

        // =========================================================
        // phase accumulator and offset
        next_st.acc = st.acc + fword;
        next_st.ph  = st.acc[ddsrs_pkg::FREQ_W-1:ACC_LSB] + poff;

        // =========================================================
        // phase to amplitude
        if (st.ctrl[ddsrs_pkg::CB_MODE]) begin
            next_st.dac = tri_wave(st.ph);
        end else begin
            next_st.dac = sine_lookup(st.ph);
        end

        // =========================================================
        // halved msb toggles on each msb rising edge
        // divider phase is free running, not aligned to control loads
        msb = st.dac[ddsrs_pkg::PHASE_W-1];
        next_st.msb_prev = msb;
        if (msb && !st.msb_prev) begin
            next_st.half = ~st.half;
        end

        // =========================================================
        // square output source and divide
        dig = st.ctrl[ddsrs_pkg::CB_DIV] ? msb : st.half;
        next_st.sq = st.ctrl[ddsrs_pkg::CB_SRC] ? comparator_i : dig;
        // released pin reads low on the link
        next_st.oe = st.ctrl[ddsrs_pkg::CB_OPEN];
    end

    // =========================================================
    // state register
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            // pin mode starts off, so the control bits select first
            st.ctrl     <= ddsrs_pkg::CTRL_RST;
            st.f0       <= ddsrs_pkg::FREQ_RST;
            st.f1       <= ddsrs_pkg::FREQ_RST;
            st.p0       <= ddsrs_pkg::PHASE_RST;
            st.p1       <= ddsrs_pkg::PHASE_RST;
            st.acc      <= ddsrs_pkg::FREQ_RST;
            st.ph       <= ddsrs_pkg::PHASE_RST;
            st.dac      <= ddsrs_pkg::PHASE_RST;
            st.msb_prev <= 1'b0;
            st.half     <= 1'b0;
            st.sq       <= 1'b0;
            st.oe       <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // =========================================================
    // outputs straight from registers
    assign link.sq_out = st.sq;
    assign link.sq_oe  = st.oe;
    assign dac_code_o  = st.dac;
    assign mode_o      = st.ctrl[ddsrs_pkg::CB_MODE];
    assign phase_o     = st.ph;
endmodule
`default_nettype wire

// ==== logic/ddsrs_pkg.sv ====
// shared constants and types for the dds register select and square output ends
package ddsrs_pkg;
    localparam int FREQ_W      = 28;
    localparam int PHASE_W     = 12;
    localparam int CTRL_W      = 16;
    // control word bit positions
    localparam int CB_FREQ_CHOICE_BIT     = 11;
    localparam int CB_PSEL     = 10;
    localparam int CB_PINSW    = 9;
    localparam int CB_OPEN     = 5;
    localparam int CB_SRC      = 4;
    localparam int CB_DIV      = 3;
    localparam int CB_RSVD_HI  = 2;
    localparam int CB_MODE     = 1;
    localparam int CB_RSVD_LO  = 0;
    localparam logic [CTRL_W-1:0]  CTRL_RST  = 16'h0000;
    localparam logic [FREQ_W-1:0]  FREQ_RST  = 28'h0000000;
    localparam logic [PHASE_W-1:0] PHASE_RST = 12'h000;
    // load select codes on the host side write strobe
    typedef enum logic [2:0] {
        DDSRS_LD_CTRL,
        DDSRS_LD_F0,
        DDSRS_LD_F1,
        DDSRS_LD_P0,
        DDSRS_LD_P1
    } ddsrs_ld_t;
endpackage

// ==== logic/ddsrs_if.sv ====
// link between the host and the dds select/output device
`timescale 1ns/1ps
`default_nettype none
interface ddsrs_if;
    logic                            wr_en;        // one-cycle load strobe
    ddsrs_pkg::ddsrs_ld_t            wr_sel;       // which word is loaded
    logic [ddsrs_pkg::FREQ_W-1:0]    wr_data;      // load data, low bits used
    logic                            freq_choice_pin;
    logic                            phase_choice_pin;
    logic                            sq_out;       // square pin data
    logic                            sq_oe;        // square pin output enable
    logic                            sq_pin;       // resolved pin level
    assign sq_pin = sq_oe ? sq_out : 1'b0;
    modport host (
        output wr_en, wr_sel, wr_data, freq_choice_pin, phase_choice_pin,
        input  sq_pin
    );
    modport device (
        input  wr_en, wr_sel, wr_data, freq_choice_pin, phase_choice_pin,
        output sq_out, sq_oe
    );
endinterface
`default_nettype wire

// ==== logic/ddsrs_host.sv ====
// host end: loads words and drives the select pins
`timescale 1ns/1ps
`default_nettype none
module ddsrs_host (
    input  wire logic                         sys_clk_i,   // system clock
    input  wire logic                         arst_n_i,    // async reset, low
    ddsrs_if.host                             link,        // device link
    input  wire logic                         req_i,       // load request pulse
    input  wire ddsrs_pkg::ddsrs_ld_t         sel_i,       // word to load
    input  wire logic [ddsrs_pkg::FREQ_W-1:0] data_i,      // word value
    input  wire logic                         fpin_i,      // wanted freq pin
    input  wire logic                         ppin_i,      // wanted phase pin
    output var  logic                         sq_level_o   // sampled square pin
);
    typedef struct packed {
        logic                         wr_en;
        ddsrs_pkg::ddsrs_ld_t         wr_sel;
        logic [ddsrs_pkg::FREQ_W-1:0] wr_data;
        logic                         fpin;
        logic                         ppin;
        logic                         sq;
    } ddsrs_hst_t;

    ddsrs_hst_t st;
    ddsrs_hst_t next_st;

    // =========================================================
    // next state
    always_comb begin
        next_st         = st;
        next_st.wr_en   = req_i;
        next_st.sq      = link.sq_pin;
        // pins stay at steady levels, changed only from registers
        next_st.fpin    = fpin_i;
        next_st.ppin    = ppin_i;
        if (req_i) begin
            next_st.wr_sel  = sel_i;
            next_st.wr_data = data_i;
            if (sel_i == ddsrs_pkg::DDSRS_LD_CTRL) begin
                next_st.wr_data[ddsrs_pkg::CB_RSVD_HI] = 1'b0;
                next_st.wr_data[ddsrs_pkg::CB_RSVD_LO] = 1'b0;
                if (data_i[ddsrs_pkg::CB_OPEN]) begin
                    next_st.wr_data[ddsrs_pkg::CB_MODE] = 1'b0;
                end
            end
        end
    end

    // =========================================================
    // state register
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign link.wr_en            = st.wr_en;
    assign link.wr_sel           = st.wr_sel;
    assign link.wr_data          = st.wr_data;
    assign link.freq_choice_pin  = st.fpin;
    assign link.phase_choice_pin = st.ppin;
    assign sq_level_o            = st.sq;
endmodule
`default_nettype wire

// ==== tb/ddsrs_asserts.sv ====
// concurrent checks on the host to device link
`timescale 1ns/1ps
`default_nettype none
module ddsrs_asserts (
    input wire logic                         sys_clk_i, // clock
    input wire logic                         arst_n_i,  // async reset, low
    input wire logic                         wr_en,     // load strobe
    input wire ddsrs_pkg::ddsrs_ld_t         wr_sel,    // load target
    input wire logic [ddsrs_pkg::FREQ_W-1:0] wr_data,   // load value
    input wire logic                         sq_out,    // square data
    input wire logic                         sq_oe      // square enable
);
    logic [15:0] ctl;
    logic        ld_ctl;
    assign ld_ctl = wr_en && (wr_sel == ddsrs_pkg::DDSRS_LD_CTRL);
    // ====================
    // control word as last sent
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctl <= 16'h0000;
        end else if (ld_ctl) begin
            ctl <= wr_data[15:0];
        end
    end
    default clocking dc @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);
    // ====================
    // link checks
    rsvd_bits_zero_a: assert property (ld_ctl |-> !wr_data[2] && !wr_data[0])
        else $error("reserved control bit sent as one");
    mode_with_enable_a: assert property (ld_ctl && wr_data[5] |-> !wr_data[1])
        else $error("triangle mode sent with square enable");
    load_target_a: assert property (wr_en |-> wr_sel <= ddsrs_pkg::DDSRS_LD_P1)
        else $error("load target out of range");
    oe_released_a: assert property (!ctl[5] [*6] |-> !sq_oe)
        else $error("square pin driven while disabled");
    oe_driven_a: assert property (ctl[5] [*6] |-> sq_oe)
        else $error("square pin released while enabled");
    enable_follows_a: assert property (ld_ctl |-> ##2 (sq_oe == $past(wr_data[5], 2)))
        else $error("square enable does not follow control load");
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// testbench joining host and device ends across the link
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic                 sys_clk_i;
    logic                 arst_n_i;
    logic                 req_i;
    ddsrs_pkg::ddsrs_ld_t sel_i;
    logic [27:0]          data_i;
    logic                 fpin_i;
    logic                 ppin_i;
    logic                 cmp_i;
    logic                 sq_level_o;
    logic                 mode_o;
    logic [11:0]          phase_o;
    logic [11:0]          st;
    logic [11:0]          dac_code_o;
    int                   fail_count;
    int                   check_count;
    ddsrs_if ddsrs_if_i ();
    ddsrs_host ddsrs_host_i (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .link(ddsrs_if_i),
        .req_i(req_i), .sel_i(sel_i), .data_i(data_i), .fpin_i(fpin_i), .ppin_i(ppin_i),
        .sq_level_o(sq_level_o));
    ddsrs_device ddsrs_device_i (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .link(ddsrs_if_i),
        .comparator_i(cmp_i), .dac_code_o(dac_code_o), .mode_o(mode_o), .phase_o(phase_o));
    ddsrs_asserts ddsrs_asserts_i (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
        .wr_en(ddsrs_if_i.wr_en), .wr_sel(ddsrs_if_i.wr_sel), .wr_data(ddsrs_if_i.wr_data),
        .sq_out(ddsrs_if_i.sq_out), .sq_oe(ddsrs_if_i.sq_oe));
    initial begin
        sys_clk_i = 1'b0;
        forever #4 sys_clk_i = ~sys_clk_i;
    end
    // ====================
    // shared tasks
    task automatic chk(input logic [27:0] got, input logic [27:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic load(input ddsrs_pkg::ddsrs_ld_t s, input logic [27:0] d);
        @(posedge sys_clk_i);
        #1 req_i = 1'b1;
        sel_i = s;
        data_i = d;
        @(posedge sys_clk_i);
        #1 req_i = 1'b0;
    endtask
    task automatic settle();
        repeat (8) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ====================
    // scenarios
    task automatic phase_select_test();
        load(ddsrs_pkg::DDSRS_LD_F0, 28'h0000000);
        load(ddsrs_pkg::DDSRS_LD_F1, 28'h0000000);
        load(ddsrs_pkg::DDSRS_LD_P0, 28'h0000123);
        load(ddsrs_pkg::DDSRS_LD_P1, 28'h0000ABC);
        for (int i = 0; i < 4; i++) begin
            // pin held opposite in software mode, so it must be ignored
            ppin_i = i[1] ? i[0] : !i[0];
            load(ddsrs_pkg::DDSRS_LD_CTRL, i[1] ? 28'h0000200 : (i[0] ? 28'h0000400 : 28'h0));
            settle();
            chk(phase_o, i[0] ? 28'h0000ABC : 28'h0000123);
        end
    endtask
    task automatic freq_select_test();
        load(ddsrs_pkg::DDSRS_LD_F0, 28'h0010000);
        load(ddsrs_pkg::DDSRS_LD_F1, 28'h0030000);
        for (int i = 0; i < 4; i++) begin
            fpin_i = i[1] ? i[0] : !i[0];
            load(ddsrs_pkg::DDSRS_LD_CTRL, i[1] ? 28'h0000200 : (i[0] ? 28'h0000800 : 28'h0));
            settle();
            st = phase_o;
            @(posedge sys_clk_i);
            #1 st = phase_o - st;
            chk(st, i[0] ? 28'h3 : 28'h1);
        end
    endtask
    task automatic mode_test();
        logic [11:0] top;
        load(ddsrs_pkg::DDSRS_LD_F0, 28'h0000000);
        load(ddsrs_pkg::DDSRS_LD_F1, 28'h0000000);
        load(ddsrs_pkg::DDSRS_LD_P0, 28'h0000000);
        load(ddsrs_pkg::DDSRS_LD_CTRL, 28'h0000000);
        settle();
        top = phase_o;
        load(ddsrs_pkg::DDSRS_LD_P0, {16'h0000, 12'h000 - top});
        settle();
        chk(phase_o, 28'h0000000);
        chk(dac_code_o, 28'h0000800);
        load(ddsrs_pkg::DDSRS_LD_CTRL, 28'h0000002);
        settle();
        chk(mode_o, 1'b1);
        chk(dac_code_o, 28'h0000000);
        load(ddsrs_pkg::DDSRS_LD_CTRL, 28'h0000022);
        settle();
        chk(mode_o, 1'b0);
    endtask
    task automatic square_test();
        int   n;
        logic prev;
        cmp_i = 1'b1;
        load(ddsrs_pkg::DDSRS_LD_CTRL, 28'h0000038);
        settle();
        chk(sq_level_o, 1'b1);
        cmp_i = 1'b0;
        settle();
        chk(sq_level_o, 1'b0);
        cmp_i = 1'b1;
        load(ddsrs_pkg::DDSRS_LD_CTRL, 28'h0000018);
        settle();
        chk(sq_level_o, 1'b0);
        cmp_i = 1'b1;
        load(ddsrs_pkg::DDSRS_LD_CTRL, 28'h0000030);
        settle();
        chk(sq_level_o, 1'b1);
        cmp_i = 1'b0;
        load(ddsrs_pkg::DDSRS_LD_F0, 28'h1000000);
        for (int k = 0; k < 2; k++) begin
            // msb period is 16 cycles: 8 toggles direct, 4 halved in 64
            load(ddsrs_pkg::DDSRS_LD_CTRL, k[0] ? 28'h0000028 : 28'h0000020);
            settle();
            n = 0;
            prev = sq_level_o;
            repeat (64) begin
                @(posedge sys_clk_i);
                #1;
                if (sq_level_o !== prev) begin
                    n++;
                end
                prev = sq_level_o;
            end
            chk(28'(n), k[0] ? 28'h0000008 : 28'h0000004);
        end
    endtask
    initial begin
        fail_count = 0;
        check_count = 0;
        arst_n_i = 1'b0;
        req_i = 1'b0;
        sel_i = ddsrs_pkg::DDSRS_LD_CTRL;
        data_i = 28'h0000000;
        fpin_i = 1'b0;
        ppin_i = 1'b0;
        cmp_i = 1'b0;
        repeat (20) @(posedge sys_clk_i);
        #1 arst_n_i = 1'b1;
        phase_select_test();
        freq_select_test();
        mode_test();
        square_test();
        tally_and_finish();
    end
endmodule
`default_nettype wire
